// File: rtl/tmr_core.sv
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tmr_map.svh"
// ****************************************
// Overview of operation
// ****************************************
// Overview of operation
// - Event mode counts down on synchronized pin A edges
// - Mode bits select pin A counting edge
// - Event underflow sets pending A, even with enable clear
// - Pin B rising edge sets pending B
// - Event mode never drives pin A
// - Capture mode counter runs without stopping
// - Pin edges copy counter into companion registers
// - Capture edge selectable separately per pin
// - Capture events set pending flags A and B
// - Capture underflow sets run bit, shares interrupt A
// - Run bit starts and stops PWM, event count
// - Enables gate interrupts; pending flags stay set
// - Three mode bits decode all eight modes
// - Companion registers readable without disturbing count
// - Fast clock may change counter ten times
// - Control register accepts any access any time
// - One 16-bit counter plus two companions
// - PWM reloads from A first, then alternately
// - PWM underflows set pending A, B alternately
// - High-speed bit selects fast clock, optional
// ****************************************
module tmr_core
  import tmr_pkg::*;
#(
  parameter bit HS_AVAIL = 1'b1,
  parameter logic [7:0] INST_DIV = 8'(`TMR_INST_DIV)
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input tmr_wb_req_s wb_req_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic timer_pin_a_i,
  input wire logic timer_pin_b_i,
  output logic timer_pin_a_o,
  output logic timer_pin_a_oe_o,
  output logic irq_a_o,
  output logic irq_b_o
);

  // ****************************************
  // Declarations
  // ****************************************
  tmr_state_s s; // Registered state
  tmr_state_s next_s; // Next state
  logic inst_tick; // Instruction-cycle strobe
  logic rise_a, fall_a, rise_b, fall_b; // Synchronized pin edges
  logic is_pwm, is_evt, is_cap; // Mode class
  logic adv; // Clock source strobe
  logic evt_a; // Selected counting edge
  logic cap_a_ev, cap_b_ev; // Capture triggers
  logic step; // Counter decrements this cycle
  logic underflow; // Counter passes through zero
  logic wr; // Bus write takes effect

  // ****************************************
  // Helpers
  // ****************************************
  // Instruction-cycle clock source
  tmr_presc #(
    .DIV(INST_DIV)
  ) u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(inst_tick)
  );

  // Pin A synchroniser
  tmr_edge u_edge_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(timer_pin_a_i),
    .rise_o(rise_a),
    .fall_o(fall_a)
  );

  // Pin B synchroniser
  tmr_edge u_edge_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(timer_pin_b_i),
    .rise_o(rise_b),
    .fall_o(fall_b)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_s = s;
    // Mode decode from the three select bits
    is_pwm = s.mode[2] & ~s.mode[1];
    is_evt = ~s.mode[2] & ~s.mode[1];
    is_cap = s.mode[1];
    // Fast clock only where the option exists
    adv = (s.hs & HS_AVAIL) ? 1'b1 : inst_tick;
    evt_a = s.mode[0] ? fall_a : rise_a;
    cap_a_ev = is_cap & (s.mode[0] ? fall_a : rise_a);
    cap_b_ev = is_cap & (s.mode[2] ? fall_b : rise_b);
    // Capture ignores the run bit; others obey it
    if (is_cap) begin
      step = adv;
    end else if (is_evt) begin
      step = s.run_uf & evt_a;
    end else begin
      step = s.run_uf & adv;
    end
    underflow = step & (s.count == 16'h0000);
    wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & s.ack;

    // Bus: answer one cycle after the strobe, drop the next
    next_s.ack = wb_req_i.cyc & wb_req_i.stb & ~s.ack;
    case (wb_req_i.adr)
      `TMR_OFS_CTRL: begin
        next_s.rdata = {23'h00_0000, s.hs, s.en_b, s.pend_b, s.en_a, s.pend_a,
                        s.mode, s.run_uf};
      end
      `TMR_OFS_COUNT: begin
        next_s.rdata = {16'h0000, s.count};
      end
      `TMR_OFS_COMP_A: begin
        next_s.rdata = {16'h0000, s.comp_a};
      end
      `TMR_OFS_COMP_B: begin
        next_s.rdata = {16'h0000, s.comp_b};
      end
      `TMR_OFS_STATUS: begin
        next_s.rdata = {28'h000_0000, s.irq_b, s.irq_a, s.pin_a, s.reload_b};
      end
      default: begin
        // Unmapped reads return zero
        next_s.rdata = 32'h0000_0000;
      end
    endcase

    // Counter: down count, wrap or PWM reload
    if (step) begin
      if (!underflow) begin
        next_s.count = s.count - 16'h0001;
      end else if (is_pwm) begin
        next_s.count = s.reload_b ? s.comp_b : s.comp_a;
      end else begin
        next_s.count = `TMR_WRAP_VAL;
      end
    end

    // Software writes; control register safe at any time
    if (wr) begin
      case (wb_req_i.adr)
        `TMR_OFS_CTRL: begin
          if (wb_req_i.sel[0]) begin
            next_s.run_uf = wb_req_i.dat[`TMR_BIT_RUN];
            next_s.mode = wb_req_i.dat[`TMR_BIT_MODE_HI:`TMR_BIT_MODE_LO];
            next_s.pend_a = wb_req_i.dat[`TMR_BIT_PEND_A];
            next_s.en_a = wb_req_i.dat[`TMR_BIT_EN_A];
            next_s.pend_b = wb_req_i.dat[`TMR_BIT_PEND_B];
            next_s.en_b = wb_req_i.dat[`TMR_BIT_EN_B];
          end
          if (wb_req_i.sel[1]) begin
            next_s.hs = wb_req_i.dat[`TMR_BIT_HS];
          end
        end
        `TMR_OFS_COUNT: begin
          if (wb_req_i.sel[0]) next_s.count[7:0] = wb_req_i.dat[7:0];
          if (wb_req_i.sel[1]) next_s.count[15:8] = wb_req_i.dat[15:8];
        end
        `TMR_OFS_COMP_A: begin
          if (wb_req_i.sel[0]) next_s.comp_a[7:0] = wb_req_i.dat[7:0];
          if (wb_req_i.sel[1]) next_s.comp_a[15:8] = wb_req_i.dat[15:8];
        end
        `TMR_OFS_COMP_B: begin
          if (wb_req_i.sel[0]) next_s.comp_b[7:0] = wb_req_i.dat[7:0];
          if (wb_req_i.sel[1]) next_s.comp_b[15:8] = wb_req_i.dat[15:8];
        end
        default: begin
          // Writes elsewhere are ignored
        end
      endcase
    end

    // Hardware events come last so a set beats a same-cycle clear
    if (is_pwm) begin
      if (underflow) begin
        next_s.reload_b = ~s.reload_b;
        if (s.reload_b) begin
          next_s.pend_b = 1'b1;
        end else begin
          next_s.pend_a = 1'b1;
        end
        if (s.mode[0]) begin
          next_s.pin_a = ~s.pin_a;
        end
      end
    end else begin
      // Leaving PWM rearms the first reload from A
      next_s.reload_b = 1'b0;
    end
    if (is_evt) begin
      if (underflow) next_s.pend_a = 1'b1;
      if (rise_b) next_s.pend_b = 1'b1;
    end
    if (is_cap) begin
      // Capture wins over a same-cycle software write
      if (cap_a_ev) begin
        next_s.comp_a = s.count;
        next_s.pend_a = 1'b1;
      end
      if (cap_b_ev) begin
        next_s.comp_b = s.count;
        next_s.pend_b = 1'b1;
      end
      // Run bit doubles as underflow flag here
      if (underflow) next_s.run_uf = 1'b1;
    end

    // Pin A driven only by PWM modes
    next_s.pin_oe = next_s.mode[2] & ~next_s.mode[1];
    // Interrupt lines; pending flags persist until cleared
    next_s.irq_a = next_s.en_a & (next_s.pend_a |
                   (next_s.mode[1] & next_s.run_uf));
    next_s.irq_b = next_s.en_b & next_s.pend_b;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.count <= `TMR_COUNT_RST;
      s.comp_a <= `TMR_COMP_RST;
      s.comp_b <= `TMR_COMP_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdata;
  assign timer_pin_a_o = s.pin_a;
  assign timer_pin_a_oe_o = s.pin_oe;
  assign irq_a_o = s.irq_a;
  assign irq_b_o = s.irq_b;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  evt_uf_pend_a: assert property (is_evt && underflow |=> s.pend_a)
    else $error("event underflow did not set pending A");
  evt_pinb_pend_a: assert property (is_evt && rise_b |=> s.pend_b)
    else $error("pin B rise did not set pending B");
  evt_no_drive_a: assert property (is_evt |-> !timer_pin_a_oe_o)
    else $error("pin A driven in event mode");
  cap_load_a: assert property (cap_a_ev |=> s.comp_a == $past(s.count))
    else $error("capture A missed counter value");
  cap_uf_flag_a: assert property (is_cap && underflow |=> s.run_uf && irq_a_o == s.en_a)
    else $error("capture underflow flag or interrupt wrong");
  stop_hold_a: assert property (!is_cap && !s.run_uf && !wr ##1 !wr
    |-> s.count == $past(s.count))
    else $error("stopped counter changed");
  irq_gate_a: assert property (!s.en_a && !s.en_b ##1 !s.en_a && !s.en_b
    |-> !irq_a_o && !irq_b_o)
    else $error("interrupt without enable");
  pwm_alt_a: assert property (is_pwm && underflow && !s.reload_b && !wr
    |=> s.pend_a && s.reload_b && s.count == $past(s.comp_a))
    else $error("first PWM reload not from A");
  wrap_down_a: assert property (step && !is_pwm && s.count == 16'h0000 && !wr
    |=> s.count == 16'hFFFF)
    else $error("counter did not wrap to all ones");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  pwm_uf_c: cover property (is_pwm && underflow ##[1:300] is_pwm && underflow);
  cap_a_c: cover property (cap_a_ev);
  evt_uf_c: cover property (is_evt && underflow);
  cap_uf_c: cover property (is_cap && underflow && cap_a_ev);
  // Slow clock stepping while capturing
  slow_step_c: cover property (is_cap && !s.hs && step);

endmodule // tmr_core

// File: rtl/tmr_map.svh
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define TMR_OFS_CTRL 5'h00
`define TMR_OFS_COUNT 5'h04
`define TMR_OFS_COMP_A 5'h08
`define TMR_OFS_COMP_B 5'h0C
`define TMR_OFS_STATUS 5'h10

// ****************************************
// Control register field positions
// ****************************************
`define TMR_BIT_RUN 0
`define TMR_BIT_MODE_LO 1
`define TMR_BIT_MODE_HI 3
`define TMR_BIT_PEND_A 4
`define TMR_BIT_EN_A 5
`define TMR_BIT_PEND_B 6
`define TMR_BIT_EN_B 7
`define TMR_BIT_HS 8

// ****************************************
// Reset values and counter wrap value
// ****************************************
`define TMR_COUNT_RST 16'h0000
`define TMR_COMP_RST 16'h0000
`define TMR_WRAP_VAL 16'hFFFF

// ****************************************
// Timing
// ****************************************
`define TMR_CLK_NS 25
`define TMR_INST_NS 250
`define TMR_INST_DIV (`TMR_INST_NS / `TMR_CLK_NS)

`endif

// File: rtl/tmr_pkg.sv
package tmr_pkg;

  // Mode select encodings, written as {bit3, bit2, bit1}
  typedef enum logic [2:0] {
    TMR_EVT_RISE = 3'b000,
    TMR_EVT_FALL = 3'b001,
    TMR_CAP_RR = 3'b010,
    TMR_CAP_RF = 3'b110,
    TMR_CAP_FR = 3'b011,
    TMR_CAP_FF = 3'b111,
    TMR_PWM_PLAIN = 3'b100,
    TMR_PWM_TOGGLE = 3'b101
  } tmr_mode_e;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tmr_wb_req_s;

  // Pin synchroniser and edge detector state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tmr_edge_s;

  // Instruction-cycle tick generator state
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } tmr_presc_s;

  // Whole state of the timer block
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] comp_a;
    logic [15:0] comp_b;
    logic run_uf;
    logic [2:0] mode;
    logic pend_a;
    logic en_a;
    logic pend_b;
    logic en_b;
    logic hs;
    logic reload_b;
    logic pin_a;
    logic pin_oe;
    logic irq_a;
    logic irq_b;
    logic ack;
    logic [31:0] rdata;
  } tmr_state_s;

endpackage

// File: rtl/tmr_edge.sv
`timescale 1ns/1ps
// ****************************************
// Pin synchroniser with edge pulses
// ****************************************
module tmr_edge
  import tmr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);

  tmr_edge_s s; // Current state
  tmr_edge_s next_s; // Next state

  // Stage one feeds only stage two, so metastability never reaches logic
  always_comb begin
    next_s = s;
    next_s.s1 = pin_i;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end

  // State register; reset loads every stage with the pin level,
  // so a pin that idles high gives no false edge after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{s1: pin_i, s2: pin_i, s3: pin_i};
    end else begin
      s <= next_s;
    end
  end

  // Edges seen between stage two and three
  assign rise_o = s.s2 & ~s.s3;
  assign fall_o = ~s.s2 & s.s3;

endmodule // tmr_edge

// File: rtl/tmr_presc.sv
`timescale 1ns/1ps
// ****************************************
// Instruction-cycle tick generator
// ****************************************
module tmr_presc
  import tmr_pkg::*;
#(
  parameter logic [7:0] DIV = 8'h0A
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);

  tmr_presc_s s; // Current state
  tmr_presc_s next_s; // Next state

  // One tick every DIV fast clocks
  always_comb begin
    next_s = s;
    if (s.cnt == DIV - 8'h01) begin
      next_s.cnt = 8'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
      next_s.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;

endmodule // tmr_presc

// File: tb/tmr_ext.sv
`timescale 1ns/1ps
// ****************************************
// Far-side pin source
// ****************************************
module tmr_ext (
  input wire logic clk_i,
  output logic pin_a_o,
  output logic pin_b_o
);
  // Both pins idle low until a test moves them
  initial begin
    pin_a_o = 1'b0;
    pin_b_o = 1'b0;
  end

  // Level change just after an edge; caller keeps it for several clocks,
  // since pulses under one clock may slip through the synchroniser
  task automatic set_a(input logic lvl);
    @(posedge clk_i);
    pin_a_o <= lvl;
  endtask

  // Same for pin B
  task automatic set_b(input logic lvl);
    @(posedge clk_i);
    pin_b_o <= lvl;
  endtask
endmodule // tmr_ext

// File: tb/tb.sv
`timescale 1ns/1ps
`include "tmr_map.svh"
// ****************************************
// Self-checking bench for the timer block
// ****************************************
module tb;
  import tmr_pkg::*;
  logic clk_i;
  logic rst_i;
  tmr_wb_req_s req; // Bus request
  logic ack;
  logic [31:0] wb_dat;
  logic pa_o;
  logic pa_oe;
  logic irq_a;
  logic irq_b;
  logic ext_a; // Far side level on pin A
  logic pin_b;
  logic pin_a; // Resolved pin A
  logic [31:0] rdat; // Last read data
  logic [31:0] q;
  logic [31:0] qa;
  logic [31:0] qb;
  logic [2:0] m;
  logic l0;
  logic hs_on; // High-speed bit of control words
  int fails;
  int n_tests;
  int k;
  int av;
  int bv;
  int d1;
  int d2;

  // Block drives pin A only while its enable is high
  assign pin_a = pa_oe ? pa_o : ext_a;

  // Default instruction cycle, so the slow count shows the real ratio
  tmr_core uut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(req),
    .wb_ack_o(ack),
    .wb_dat_o(wb_dat),
    .timer_pin_a_i(pin_a),
    .timer_pin_b_i(pin_b),
    .timer_pin_a_o(pa_o),
    .timer_pin_a_oe_o(pa_oe),
    .irq_a_o(irq_a),
    .irq_b_o(irq_b)
  );

  tmr_ext ext (.clk_i(clk_i), .pin_a_o(ext_a), .pin_b_o(pin_b));

  // ****************************************
  // Expectations and checks
  // ****************************************
  // Control word; high-speed bit follows hs_on
  function automatic logic [31:0] ctrl(logic [2:0] md, logic run, logic ea, logic eb);
    return {23'h0, hs_on, eb, 1'b0, ea, 1'b0, md, run};
  endfunction

  // Counter after a write through the selected byte lanes
  function automatic logic [31:0] lanes(logic [31:0] a, logic [31:0] b, logic [3:0] sl);
    return {16'h0000, sl[1] ? b[15:8] : a[15:8], sl[0] ? b[7:0] : a[7:0]};
  endfunction

  // Steps in one hundred clocks, fast or per instruction cycle
  function automatic logic [31:0] drop(logic h);
    return h ? 32'h0000_0064 : 32'(100 / `TMR_INST_DIV);
  endfunction

  // Counter after one rising pin A edge in event mode
  function automatic logic [31:0] after_rise(logic [2:0] md, logic [15:0] c);
    return {16'h0, (md == TMR_EVT_RISE) ? c - 16'h0001 : c};
  endfunction

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // One classic bus cycle; waits for ack with a bound
  task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] d,
                    input logic [3:0] sl = 4'h3);
    int n;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sl, dat: d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = wb_dat;
    if (n >= 50) begin
      fails++;
      $display("[FAIL] %0t no bus ack", $time);
    end
    req <= '0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Clocks until pin A output changes
  task automatic wait_tog(output int n);
    logic l;
    l = pa_o;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pa_o === l && n < 300);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Whole run needs under a thousand clocks
  initial begin
    #(25 * 20000);
    fails++;
    close_out();
  end

  initial begin
    rst_i = 1'b1;
    req = '0;
    fails = 0;
    n_tests = 0;
    hs_on = 1'b1;
    void'($urandom(32'h368d));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, status and an unmapped place
    wb(1'b1, 5'h14, 32'hffff_ffff);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 5'(i * 4), 32'h0);
      chk_val(rdat, 32'h0);
    end
    $display("reset test done");
    // Event counting on both edge selections
    for (int j = 0; j < 2; j++) begin
      m = 3'(j);
      wb(1'b1, `TMR_OFS_COUNT, 32'h1);
      wb(1'b1, `TMR_OFS_CTRL, ctrl(m, 1'b1, 1'b1, 1'b1));
      ext.set_a(1'b1);
      cyc(6);
      wb(1'b0, `TMR_OFS_COUNT, 32'h0);
      chk_val(rdat, after_rise(m, 16'h0001));
      ext.set_a(1'b0);
      cyc(6);
      wb(1'b0, `TMR_OFS_COUNT, 32'h0);
      chk_val(rdat, 32'h0);
      ext.set_a(1'b1);
      cyc(6);
      ext.set_a(1'b0);
      cyc(6);
      wb(1'b0, `TMR_OFS_COUNT, 32'h0);
      chk_val(rdat, 32'hffff);
      chk_bit(irq_a, 1'b1);
      chk_bit(pa_oe, 1'b0);
      ext.set_b(1'b1);
      cyc(6);
      chk_bit(irq_b, 1'b1);
      ext.set_b(1'b0);
      wb(1'b1, `TMR_OFS_CTRL, ctrl(m, 1'b0, 1'b1, 1'b1));
      cyc(2);
      chk_bit(irq_a | irq_b, 1'b0);
      ext.set_a(1'b1);
      cyc(6);
      ext.set_a(1'b0);
      cyc(6);
      wb(1'b0, `TMR_OFS_COUNT, 32'h0);
      chk_val(rdat, 32'hffff);
      $display("event test %0d done", j);
    end
    // Captures in all four edge selections; pins start at the idle level
    for (int j = 0; j < 4; j++) begin
      m = {j[1], 1'b1, j[0]};
      ext.set_a(m[0]);
      ext.set_b(m[2]);
      cyc(6);
      wb(1'b1, `TMR_OFS_COUNT, 32'h8000);
      wb(1'b1, `TMR_OFS_CTRL, ctrl(m, 1'b0, 1'b1, 1'b1));
      k = 3 + $urandom % 20;
      ext.set_a(~m[0]);
      cyc(k - 1);
      ext.set_b(~m[2]);
      cyc(8);
      wb(1'b0, `TMR_OFS_COMP_A, 32'h0);
      qa = rdat;
      wb(1'b0, `TMR_OFS_COMP_B, 32'h0);
      qb = rdat;
      chk_val(qa - qb, 32'(k));
      chk_bit(irq_a & irq_b, 1'b1);
      wb(1'b0, `TMR_OFS_COUNT, 32'h0);
      q = rdat;
      wb(1'b0, `TMR_OFS_COUNT, 32'h0);
      chk_bit(rdat < q, 1'b1);
      ext.set_a(m[0]);
      ext.set_b(m[2]);
      cyc(8);
      wb(1'b0, `TMR_OFS_COMP_A, 32'h0);
      chk_val(rdat, qa);
      wb(1'b0, `TMR_OFS_COMP_B, 32'h0);
      chk_val(rdat, qb);
      $display("capture test %0d done", j);
    end
    // Underflow in capture mode raises the run bit and interrupt A
    wb(1'b1, `TMR_OFS_CTRL, ctrl(m, 1'b0, 1'b1, 1'b0));
    wb(1'b1, `TMR_OFS_COUNT, 32'h4);
    cyc(10);
    wb(1'b0, `TMR_OFS_CTRL, 32'h0);
    chk_val(rdat & 32'h11, 32'h1);
    chk_bit(irq_a, 1'b1);
    $display("underflow test done");
    // Slow and fast clock over one hundred cycles
    for (int h = 0; h < 2; h++) begin
      hs_on = h[0];
      wb(1'b1, `TMR_OFS_CTRL, ctrl(TMR_CAP_RR, 1'b0, 1'b0, 1'b0));
      wb(1'b1, `TMR_OFS_COUNT, 32'h1000 + $urandom % 32'h8000);
      wb(1'b0, `TMR_OFS_COUNT, 32'h0);
      q = rdat;
      cyc(97);
      wb(1'b0, `TMR_OFS_COUNT, 32'h0);
      chk_val(q - rdat, drop(hs_on));
      $display("clock test %0d done", h);
    end
    // Byte lanes on a stopped counter; upper lane bits are ignored
    wb(1'b1, `TMR_OFS_CTRL, ctrl(TMR_EVT_RISE, 1'b0, 1'b0, 1'b0));
    qa = $urandom;
    qb = $urandom;
    k = $urandom % 16;
    wb(1'b1, `TMR_OFS_COUNT, qa);
    wb(1'b1, `TMR_OFS_COUNT, qb, 4'(k));
    wb(1'b0, `TMR_OFS_COUNT, 32'h0);
    chk_val(rdat, lanes(qa, qb, 4'(k)));
    $display("lane test done");
    // Alternating reloads with random on and off times
    av = 4 + $urandom % 12;
    bv = 4 + $urandom % 12;
    wb(1'b1, `TMR_OFS_CTRL, ctrl(TMR_PWM_TOGGLE, 1'b0, 1'b0, 1'b0));
    wb(1'b1, `TMR_OFS_COMP_A, 32'(av));
    wb(1'b1, `TMR_OFS_COMP_B, 32'(bv));
    wb(1'b1, `TMR_OFS_COUNT, 32'h3);
    wb(1'b1, `TMR_OFS_CTRL, ctrl(TMR_PWM_TOGGLE, 1'b1, 1'b0, 1'b0));
    wait_tog(d1);
    wait_tog(d1);
    wait_tog(d2);
    chk_val(32'(d1), 32'(av + 1));
    chk_val(32'(d2), 32'(bv + 1));
    wb(1'b0, `TMR_OFS_CTRL, 32'h0);
    chk_val(rdat & 32'h50, 32'h50);
    chk_bit(pa_oe, 1'b1);
    wb(1'b1, `TMR_OFS_CTRL, ctrl(TMR_PWM_PLAIN, 1'b1, 1'b0, 1'b0));
    l0 = pa_o;
    cyc(40);
    chk_bit(pa_o, l0);
    wb(1'b1, `TMR_OFS_CTRL, ctrl(TMR_PWM_PLAIN, 1'b0, 1'b0, 1'b0));
    wb(1'b0, `TMR_OFS_COUNT, 32'h0);
    q = rdat;
    cyc(20);
    wb(1'b0, `TMR_OFS_COUNT, 32'h0);
    chk_val(rdat, q);
    $display("pwm test done");
    // Reset in mid-run with both far-side pins high: no stray edge
    ext.set_a(1'b1);
    ext.set_b(1'b1);
    rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    wb(1'b0, `TMR_OFS_CTRL, 32'h0);
    chk_val(rdat, 32'h0);
    chk_bit(pa_o | pa_oe | irq_a | irq_b, 1'b0);
    $display("reset test 2 done");
    close_out();
  end
endmodule // tb
